// ==== cers_timer.sv ====
/*
  Holds the shared constants package of the Exposing_out_n and readout
  sequencer and its phase timer, a loadable down counter.
  Assumes one clock, i_ref_clk at 20 MHz, and a synchronous active-high
  reset i_sys_rst.
*/
package cers_pkg;

  // clock and pixel format
  localparam int CLK_PERIOD_NS = 50;
  localparam int CYC_PER_US    = 1000 / CLK_PERIOD_NS;
  localparam int PIX_BITS      = 12;
  localparam int TIMER_BITS    = 32;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_EXP    = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  // control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_BIN_LSB  = 2;
  localparam int CTRL_SENS_LSB = 4;
  localparam int CTRL_TRIG_BIT = 9;

  // status register fields
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_EXP_BIT   = 1;
  localparam int STAT_RDO_BIT   = 2;
  localparam int STAT_SEC_BIT   = 3;
  localparam int STAT_FRAME_LSB = 16;

  // exposure modes
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_VIDEO  = 2'h1;
  localparam logic [1:0] MODE_DUAL   = 2'h2;

  // vertical binning codes
  localparam logic [1:0] VERTICAL_BIN_ONE  = 2'h0;
  localparam logic [1:0] VERTICAL_BIN_TWO  = 2'h1;
  localparam logic [1:0] VERTICAL_BIN_FOUR = 2'h2;

  // sensor variant codes
  localparam logic [2:0] SENS_SMALL_A = 3'h0;
  localparam logic [2:0] SENS_SMALL_B = 3'h1;
  localparam logic [2:0] SENS_SCIENCE = 3'h2;
  localparam logic [2:0] SENS_HIGHRES = 3'h3;
  localparam logic [2:0] SENS_HIGHQE  = 3'h4;

  // colour tags of the filter mosaic
  localparam logic [1:0] COLOR_RED   = 2'h0;
  localparam logic [1:0] COLOR_GREEN = 2'h1;
  localparam logic [1:0] COLOR_BLUE  = 2'h2;

  // reset values
  localparam logic [1:0]  RST_MODE   = MODE_SINGLE;
  localparam logic [1:0]  RST_BIN    = VERTICAL_BIN_ONE;
  localparam logic [2:0]  RST_SENS   = SENS_SMALL_A;
  localparam logic [13:0] RST_EXP_US = 14'h03E8;

  // first exposure range in microseconds
  localparam logic [13:0] EXP_MIN_US = 14'h000A;
  localparam logic [13:0] EXP_MAX_US = 14'h2710;

  // dead time between the two dual-frame images
  localparam int DEAD_NS  = 1000;
  localparam int DEAD_CYC = (DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // readout times in microseconds
  localparam int RDO_SA_B1_US = 19800;
  localparam int RDO_SA_B2_US = 10300;
  localparam int RDO_SA_B4_US = 5600;
  localparam int RDO_SB_B1_US = 24800;
  localparam int RDO_SB_B2_US = 12800;
  localparam int RDO_SB_B4_US = 6800;
  localparam int RDO_SC_B1_US = 79800;
  localparam int RDO_SC_B2_US = 40300;
  localparam int RDO_HR_B1_US = 104000;
  localparam int RDO_HR_B2_US = 52500;
  localparam int RDO_QE_B1_US = 88300;
  localparam int RDO_QE_B2_US = 44800;

endpackage

module cers_timer
  import cers_pkg::*;
#(
  parameter int W = TIMER_BITS
) (
  // clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_sys_rst,
  // load request
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_load_val,
  // count reached zero
  output logic              o_expired
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         expired;
  } cers_tmr_type;

  cers_tmr_type tmr_ff;
  cers_tmr_type nxt_tmr;

  // a load of n expires after n further edges
  always_comb begin
    nxt_tmr = tmr_ff;
    if (i_load) begin
      nxt_tmr.cnt = i_load_val;
    end else if (tmr_ff.cnt != '0) begin
      nxt_tmr.cnt = tmr_ff.cnt - W'(1);
    end
    nxt_tmr.expired = (nxt_tmr.cnt == '0);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      tmr_ff <= '{cnt: '0, expired: 1'b1};
    end else begin
      tmr_ff <= nxt_tmr;
    end
  end

  assign o_expired = tmr_ff.expired;

endmodule

// ==== cers_top.sv ====
/*
  Exposure and readout sequencer of a CCD camera head: starts exposures
  on software or external triggers, drives the busy, exposing and reading
  indicators and streams 12-bit pixels at one per clock.
  Assumes i_ref_clk is the sensor pixel clock, all inputs are synchronous
  to it, and the receiving FIFO never stalls the stream.
*/
module cers_top
  import cers_pkg::*;
#(
  parameter int          CYCLES_PER_US = CYC_PER_US,
  parameter int          LINE_PIXELS   = 1280,
  parameter bit          HAS_DUAL      = 1'b1
) (
  // clock and reset
  input  wire logic                i_ref_clk,
  input  wire logic                i_sys_rst,
  // register port
  input  wire logic [7:0]          i_addr,
  input  wire logic [31:0]         i_wr_data,
  input  wire logic                i_wr_en,
  input  wire logic                i_rd_en,
  output logic      [31:0]         o_rd_data,
  // trigger and sensor samples
  input  wire logic                i_ext_trig,
  input  wire logic [PIX_BITS-1:0] i_pix_data,
  // indicator outputs
  output logic                     o_busy_n,
  output logic                     o_exposing_out_n,
  output logic                     o_reading_out_n,
  // pixel stream
  output logic                     o_pix_valid,
  output logic                     o_pix_first,
  output logic      [PIX_BITS-1:0] o_pix_data,
  output logic      [1:0]          o_pix_color
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_EXPOSE,
    ST_GAP,
    ST_READ,
    ST_READ2
  } cers_state_type;

  typedef struct packed {
    cers_state_type      st;
    logic                trig_prev;
    logic                soft_trig;
    logic [1:0]          mode_cfg;
    logic [1:0]          bin_cfg;
    logic [2:0]          sens_cfg;
    logic [13:0]         exp_us;
    logic [1:0]          mode_lat;
    logic [1:0]          bin_lat;
    logic [2:0]          sens_lat;
    logic [15:0]         col;
    logic [15:0]         row;
    logic [15:0]         frames;
    logic [31:0]         rd_data;
    logic                busy_n;
    logic                exp_n;
    logic                rdo_n;
    logic                pix_valid;
    logic                pix_first;
    logic [PIX_BITS-1:0] pix_data;
    logic [1:0]          pix_color;
  } cers_regs_type;

  cers_regs_type regs_ff;
  cers_regs_type nxt_regs;

  logic                  tmr_load;
  logic [TIMER_BITS-1:0] tmr_val;
  logic                  tmr_expired;
  logic                  trig_hit;
  logic [TIMER_BITS-1:0] exp_cyc;
  logic [TIMER_BITS-1:0] rdo_cyc;
  logic [13:0]           wr_exp;

  // readout length in microseconds for a sensor and binning factor
  function automatic logic [TIMER_BITS-1:0] rdo_us(input logic [2:0] sens,
                                                    input logic [1:0] bin);
    int us;
    us = RDO_SA_B1_US;
    case (sens)
      SENS_SMALL_A: us = (bin == VERTICAL_BIN_ONE) ? RDO_SA_B1_US :
                         (bin == VERTICAL_BIN_TWO) ? RDO_SA_B2_US : RDO_SA_B4_US;
      SENS_SMALL_B: us = (bin == VERTICAL_BIN_ONE) ? RDO_SB_B1_US :
                         (bin == VERTICAL_BIN_TWO) ? RDO_SB_B2_US : RDO_SB_B4_US;
      SENS_SCIENCE: us = (bin == VERTICAL_BIN_ONE) ? RDO_SC_B1_US : RDO_SC_B2_US;
      SENS_HIGHRES: us = (bin == VERTICAL_BIN_ONE) ? RDO_HR_B1_US : RDO_HR_B2_US;
      SENS_HIGHQE:  us = (bin == VERTICAL_BIN_ONE) ? RDO_QE_B1_US : RDO_QE_B2_US;
      default:      us = RDO_SA_B1_US;
    endcase
    return TIMER_BITS'(us);
  endfunction

  // phase timer shared by exposure, dead time and readout
  cers_timer #(
    .W          (TIMER_BITS)
  ) u_timer (
    .i_ref_clk  (i_ref_clk),
    .i_sys_rst  (i_sys_rst),
    .i_load     (tmr_load),
    .i_load_val (tmr_val),
    .o_expired  (tmr_expired)
  );

  // phase lengths in clock cycles, less one for the timer load edge
  always_comb begin
    exp_cyc = TIMER_BITS'(regs_ff.exp_us * CYCLES_PER_US) - TIMER_BITS'(1);
    rdo_cyc = TIMER_BITS'(rdo_us(regs_ff.sens_lat, regs_ff.bin_lat) * CYCLES_PER_US)
              - TIMER_BITS'(1);
  end

  // out-of-range exposure writes are clamped, not rejected
  always_comb begin
    wr_exp = i_wr_data[13:0];
    if (i_wr_data[31:14] != '0 || i_wr_data[13:0] > EXP_MAX_US) begin
      wr_exp = EXP_MAX_US;
    end else if (i_wr_data[13:0] < EXP_MIN_US) begin
      wr_exp = EXP_MIN_US;
    end
  end

  // a trigger from either source only counts while idle
  assign trig_hit = (regs_ff.st == ST_IDLE) &&
                    ((i_ext_trig && !regs_ff.trig_prev) || regs_ff.soft_trig);

  // next-state logic: registers, sequencer and pixel stream
  always_comb begin
    nxt_regs           = regs_ff;
    nxt_regs.trig_prev = i_ext_trig;
    nxt_regs.soft_trig = 1'b0;
    nxt_regs.rd_data   = '0;
    tmr_load           = 1'b0;
    tmr_val            = '0;

    // register writes; config may change any time, the run uses latched copies except exp_us and the video stop check
    if (i_wr_en) begin
      case (i_addr)
        ADDR_CTRL: begin
          nxt_regs.mode_cfg  = i_wr_data[CTRL_MODE_LSB +: 2];
          nxt_regs.bin_cfg   = i_wr_data[CTRL_BIN_LSB +: 2];
          nxt_regs.sens_cfg  = i_wr_data[CTRL_SENS_LSB +: 3];
          nxt_regs.soft_trig = i_wr_data[CTRL_TRIG_BIT];
        end
        ADDR_EXP: begin
          nxt_regs.exp_us = wr_exp;
        end
        default: begin
          nxt_regs.soft_trig = 1'b0;
        end
      endcase
    end

    // register reads; unmapped addresses answer zero
    if (i_rd_en) begin
      case (i_addr)
        ADDR_CTRL: begin
          nxt_regs.rd_data[CTRL_MODE_LSB +: 2] = regs_ff.mode_cfg;
          nxt_regs.rd_data[CTRL_BIN_LSB +: 2]  = regs_ff.bin_cfg;
          nxt_regs.rd_data[CTRL_SENS_LSB +: 3] = regs_ff.sens_cfg;
        end
        ADDR_EXP: begin
          nxt_regs.rd_data[13:0] = regs_ff.exp_us;
        end
        ADDR_STATUS: begin
          nxt_regs.rd_data[STAT_BUSY_BIT]        = !regs_ff.busy_n;
          nxt_regs.rd_data[STAT_EXP_BIT]         = !regs_ff.exp_n;
          nxt_regs.rd_data[STAT_RDO_BIT]         = !regs_ff.rdo_n;
          nxt_regs.rd_data[STAT_SEC_BIT]         = (regs_ff.st == ST_READ2);
          nxt_regs.rd_data[STAT_FRAME_LSB +: 16] = regs_ff.frames;
        end
        default: begin
          nxt_regs.rd_data = '0;
        end
      endcase
    end

    // sequencer
    case (regs_ff.st)
      ST_IDLE: begin
        if (trig_hit) begin
          nxt_regs.st       = ST_EXPOSE;
          nxt_regs.bin_lat  = regs_ff.bin_cfg;
          nxt_regs.sens_lat = regs_ff.sens_cfg;
          // without the dual-frame option that mode falls back to single
          nxt_regs.mode_lat = (regs_ff.mode_cfg == MODE_DUAL && !HAS_DUAL) ?
                              MODE_SINGLE : regs_ff.mode_cfg;
          tmr_load          = 1'b1;
          tmr_val           = exp_cyc;
        end
      end
      ST_EXPOSE: begin
        if (tmr_expired) begin
          tmr_load = 1'b1;
          if (regs_ff.mode_lat == MODE_DUAL) begin
            nxt_regs.st = ST_GAP;
            tmr_val     = TIMER_BITS'(DEAD_CYC - 1);
          end else begin
            nxt_regs.st  = ST_READ;
            tmr_val      = rdo_cyc;
            nxt_regs.col = '0;
            nxt_regs.row = '0;
          end
        end
      end
      ST_GAP: begin
        if (tmr_expired) begin
          nxt_regs.st  = ST_READ;
          tmr_load     = 1'b1;
          tmr_val      = rdo_cyc;
          nxt_regs.col = '0;
          nxt_regs.row = '0;
        end
      end
      ST_READ: begin
        if (tmr_expired) begin
          nxt_regs.frames = regs_ff.frames + 16'h0001;
          nxt_regs.col    = '0;
          nxt_regs.row    = '0;
          if (regs_ff.mode_lat == MODE_DUAL) begin
            // second image was exposed during this readout, now read it
            nxt_regs.st = ST_READ2;
            tmr_load    = 1'b1;
            tmr_val     = rdo_cyc;
          end else if (regs_ff.mode_lat == MODE_VIDEO &&
                       regs_ff.mode_cfg == MODE_VIDEO) begin
            // video repeats until software selects another mode
            nxt_regs.st = ST_EXPOSE;
            tmr_load    = 1'b1;
            tmr_val     = exp_cyc;
          end else begin
            nxt_regs.st = ST_IDLE;
          end
        end
      end
      ST_READ2: begin
        if (tmr_expired) begin
          nxt_regs.frames = regs_ff.frames + 16'h0001;
          nxt_regs.st     = ST_IDLE;
        end
      end
      default: begin
        nxt_regs.st = ST_IDLE;
      end
    endcase

    // indicators follow the next state so they change on the phase edge
    nxt_regs.busy_n = (nxt_regs.st == ST_IDLE);
    nxt_regs.exp_n  = !((nxt_regs.st == ST_EXPOSE) ||
                        (nxt_regs.st == ST_READ && regs_ff.mode_lat == MODE_DUAL &&
                         regs_ff.st != ST_IDLE));
    nxt_regs.rdo_n  = !((nxt_regs.st == ST_READ) || (nxt_regs.st == ST_READ2));

    // one sample per clock while reading: 2 bytes x clock rate
    nxt_regs.pix_valid = (regs_ff.st == ST_READ) || (regs_ff.st == ST_READ2);
    nxt_regs.pix_first = 1'b0;
    nxt_regs.pix_data  = '0;
    nxt_regs.pix_color = COLOR_RED;
    if (nxt_regs.pix_valid) begin
      nxt_regs.pix_data  = i_pix_data;
      nxt_regs.pix_first = (regs_ff.col == '0) && (regs_ff.row == '0);
      // even rows red/green, odd rows green/blue, origin always red
      case ({regs_ff.row[0], regs_ff.col[0]})
        2'h0:    nxt_regs.pix_color = COLOR_RED;
        2'h3:    nxt_regs.pix_color = COLOR_BLUE;
        default: nxt_regs.pix_color = COLOR_GREEN;
      endcase
      if (tmr_load) begin
        // counters were reset above for the next image
        nxt_regs.pix_first = nxt_regs.pix_first;
      end else if (regs_ff.col == 16'(LINE_PIXELS - 1)) begin
        nxt_regs.col = '0;
        nxt_regs.row = regs_ff.row + 16'h0001;
      end else begin
        nxt_regs.col = regs_ff.col + 16'h0001;
      end
    end
  end

  // state register
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      regs_ff           <= '0;
      regs_ff.st        <= ST_IDLE;
      regs_ff.mode_cfg  <= RST_MODE;
      regs_ff.bin_cfg   <= RST_BIN;
      regs_ff.sens_cfg  <= RST_SENS;
      regs_ff.exp_us    <= RST_EXP_US;
      regs_ff.mode_lat  <= RST_MODE;
      regs_ff.bin_lat   <= RST_BIN;
      regs_ff.sens_lat  <= RST_SENS;
      regs_ff.busy_n    <= 1'b1;
      regs_ff.exp_n     <= 1'b1;
      regs_ff.rdo_n     <= 1'b1;
      regs_ff.trig_prev <= 1'b1; // a trigger held high through reset is no edge
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  // outputs straight from flops
  assign o_rd_data        = regs_ff.rd_data;
  assign o_busy_n         = regs_ff.busy_n;
  assign o_exposing_out_n = regs_ff.exp_n;
  assign o_reading_out_n  = regs_ff.rdo_n;
  assign o_pix_valid      = regs_ff.pix_valid;
  assign o_pix_first      = regs_ff.pix_first;
  assign o_pix_data       = regs_ff.pix_data;
  assign o_pix_color      = regs_ff.pix_color;

endmodule

// ==== cers_top_props.sv ====
/*
  Port checker of the exposure and readout sequencer, bound into cers_top.
  Assumes one clock domain and the synchronous active-high reset.
*/
module cers_top_props
  import cers_pkg::*;
#(
  parameter int CYCLES_PER_US = CYC_PER_US
) (
  // clock and reset
  input logic                i_ref_clk,
  input logic                i_sys_rst,
  // register port
  input logic [7:0]          i_addr,
  input logic [31:0]         i_wr_data,
  input logic                i_wr_en,
  input logic                i_rd_en,
  input logic [31:0]         o_rd_data,
  // trigger and samples
  input logic                i_ext_trig,
  input logic [PIX_BITS-1:0] i_pix_data,
  // indicators and stream
  input logic                o_busy_n,
  input logic                o_exposing_out_n,
  input logic                o_reading_out_n,
  input logic                o_pix_valid,
  input logic                o_pix_first,
  input logic [PIX_BITS-1:0] o_pix_data,
  input logic [1:0]          o_pix_color
);
  localparam int EXP_LO = 10 * CYCLES_PER_US;
  int ecnt;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  // length of the running exposure, judged on the cycle it ends
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || o_exposing_out_n) begin
      ecnt <= 0;
    end else begin
      ecnt <= ecnt + 1;
    end
  end

  a_exp_in_busy: assert property (!o_exposing_out_n |-> !o_busy_n)
    else $error("exposing without busy");
  a_rdo_in_busy: assert property (!o_reading_out_n |-> !o_busy_n)
    else $error("reading without busy");
  a_busy_ends_rdo: assert property ($rose(o_busy_n) |-> $rose(o_reading_out_n))
    else $error("busy ended apart from readout");
  a_trig_starts: assert property (o_busy_n && $rose(i_ext_trig) |=>
    !o_busy_n && !o_exposing_out_n)
    else $error("trigger edge did not start exposure");
  a_exp_min_len: assert property ($rose(o_exposing_out_n) |-> ecnt >= EXP_LO)
    else $error("exposure shorter than minimum");
  a_valid_lag: assert property (o_pix_valid == !$past(o_reading_out_n))
    else $error("pixel valid not one cycle behind readout");
  a_pix_pass: assert property (o_pix_valid |-> o_pix_data == $past(i_pix_data))
    else $error("pixel sample altered");
  a_first_red: assert property ($rose(o_pix_valid) |->
    o_pix_first && o_pix_color == COLOR_RED)
    else $error("image does not start on red");
  a_rd_quiet: assert property (!$past(i_rd_en) |-> o_rd_data == 32'h0)
    else $error("read data outside answer cycle");
  a_rd_unmap: assert property ($past(i_rd_en) && $past(i_addr) > ADDR_STATUS |->
    o_rd_data == 32'h0)
    else $error("unmapped read not zero");

  // inside a line a red sample is always followed by green; assumes even lines
  a_mosaic_order: assert property (o_pix_valid && !o_pix_first && $past(o_pix_valid) &&
    $past(o_pix_color) == COLOR_RED |-> o_pix_color == COLOR_GREEN)
    else $error("red sample not followed by green");

  c_dual_overlap: cover property (!o_exposing_out_n && !o_reading_out_n);
  c_frame_done: cover property ($rose(o_busy_n));
  c_first_pix: cover property (o_pix_first);
endmodule

bind cers_top cers_top_props #(.CYCLES_PER_US(CYCLES_PER_US)) u_cers_top_props (.*);

// ==== cers_host_model.sv ====
/*
  Receiving board model: trigger logic and a fifo that sinks every pixel.
  Assumes the bench asks for a trigger with a one-cycle i_fire pulse.
*/
module cers_host_model
  import cers_pkg::*;
(
  // clock and reset
  input  logic       i_ref_clk,
  input  logic       i_sys_rst,
  // trigger request and line
  input  logic       i_fire,
  output logic       o_ext_trig,
  // pixel stream in, tallies out
  input  logic       i_pix_valid,
  input  logic       i_pix_first,
  input  logic [1:0] i_pix_color,
  output int         o_pix_cnt,
  output int         o_bad_first,
  // shutter indicators in, light pulses out
  input  logic       i_busy_n,
  input  logic       i_exp_n,
  input  int         i_exp_cyc,
  output int         o_pulses
);
  int   hold;
  int   since;
  logic exp_prev;
  logic light;

  // trigger held a few cycles, then low so the next one is a fresh edge
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      hold <= 0;
    end else if (i_fire) begin
      hold <= 3;
    end else if (hold > 0) begin
      hold <= hold - 1;
    end
  end
  assign o_ext_trig = (hold > 0);

  // no ready line: the fifo drains in real time and takes every cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_pix_cnt   <= 0;
      o_bad_first <= 0;
    end else begin
      if (i_pix_valid) o_pix_cnt <= o_pix_cnt + 1;
      if (i_pix_first && i_pix_color !== COLOR_RED) o_bad_first <= o_bad_first + 1;
    end
  end

  // light pulses timed from the busy fall: last cycle of image one and first
  // cycle of image two; both need the shutter open, so none lands in dead time
  assign light = !i_busy_n && !i_exp_n &&
                 ((since == i_exp_cyc - 1) || (since > 0 && exp_prev));

  // cycles since busy fell, previous shutter level and pulse tally
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      since    <= 0;
      exp_prev <= 1'b1;
      o_pulses <= 0;
    end else begin
      since    <= i_busy_n ? 0 : since + 1;
      exp_prev <= i_exp_n;
      if (light) o_pulses <= o_pulses + 1;
    end
  end
endmodule

// ==== cers_tb_top.sv ====
/*
  Self-checking bench of the sequencer with the receiving board model.
  Assumes times scaled by CYCLES_PER_US = 1, so one microsecond is a cycle.
*/
module cers_tb_top;
  import cers_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int CPU = 1;
  logic                ref_clk   = 1'b0;
  logic                sys_rst   = 1'b1;
  logic [7:0]          addr      = 8'h00;
  logic [31:0]         wr_data   = 32'h0;
  logic                wr_en     = 1'b0;
  logic                rd_en     = 1'b0;
  logic                fire      = 1'b0;
  logic [PIX_BITS-1:0] pix_in    = 12'h000;
  logic [31:0]         rd_data, v;
  logic                ext_trig, busy_n, exp_n, rdo_n, pix_valid, pix_first;
  logic [PIX_BITS-1:0] pix_out;
  logic [1:0]          pix_color;
  int                  pix_cnt, bad_first, ec, bc, rsum, pulses, lite;
  int                  n_fail    = 0;
  int                  tests_run = 0;
  int                  eq[$], bq[$];

  cers_top #(.CYCLES_PER_US(CPU), .LINE_PIXELS(16), .HAS_DUAL(1'b1)) u_cers_top (
    .i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_addr(addr), .i_wr_data(wr_data),
    .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rd_data(rd_data), .i_ext_trig(ext_trig),
    .i_pix_data(pix_in), .o_busy_n(busy_n), .o_exposing_out_n(exp_n),
    .o_reading_out_n(rdo_n), .o_pix_valid(pix_valid), .o_pix_first(pix_first),
    .o_pix_data(pix_out), .o_pix_color(pix_color));
  cers_host_model u_cers_host_model (
    .i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_fire(fire), .o_ext_trig(ext_trig),
    .i_pix_valid(pix_valid), .i_pix_first(pix_first), .i_pix_color(pix_color),
    .o_pix_cnt(pix_cnt), .o_bad_first(bad_first), .i_busy_n(busy_n), .i_exp_n(exp_n),
    .i_exp_cyc(lite), .o_pulses(pulses));

  // clock and random sensor samples
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) pix_in <= 12'($urandom);

  // monitor: lengths of exposing and busy runs, total readout cycles
  always @(posedge ref_clk) begin
    if (!exp_n) ec++;
    else if (ec > 0) begin eq.push_back(ec); ec = 0; end
    if (!busy_n) bc++;
    else if (bc > 0) begin bq.push_back(bc); bc = 0; end
    if (!rdo_n) rsum++;
  end

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (e !== g) begin
      n_fail++;
      $display("BAD %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk);
    addr <= a; wr_data <= d; wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  // answer stands only in the cycle after the strobe, so look just past that edge
  task automatic rd(logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a; rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask

  task automatic pulse();
    @(posedge ref_clk) fire <= 1'b1;
    @(posedge ref_clk) fire <= 1'b0;
  endtask

  // reference readout lengths; four-fold binning falls back to two where absent
  function automatic int rdo(logic [2:0] s, logic [1:0] b);
    int t[5][3] = '{'{RDO_SA_B1_US, RDO_SA_B2_US, RDO_SA_B4_US},
      '{RDO_SB_B1_US, RDO_SB_B2_US, RDO_SB_B4_US},
      '{RDO_SC_B1_US, RDO_SC_B2_US, RDO_SC_B2_US},
      '{RDO_HR_B1_US, RDO_HR_B2_US, RDO_HR_B2_US},
      '{RDO_QE_B1_US, RDO_QE_B2_US, RDO_QE_B2_US}};
    return t[s][b] * CPU;
  endfunction

  // one triggered sequence, judged against the reference timeline
  task automatic run(logic [1:0] m, logic [1:0] b, logic [2:0] s, int e, bit ext);
    int n, r, k, f, p;
    logic [31:0] ctl, st;
    n = ((e < 10) ? 10 : ((e > 10000) ? 10000 : e)) * CPU;
    r = rdo(s, b);
    f = (m == MODE_SINGLE) ? 1 : 2;
    ctl = 32'(m) | (32'(b) << 2) | (32'(s) << 4);
    eq.delete(); bq.delete(); rsum = 0; k = pix_cnt;
    p = pulses;
    lite = n;
    wr(ADDR_EXP, 32'(e));
    wr(ADDR_CTRL, ctl);
    if (ext) pulse();
    else wr(ADDR_CTRL, ctl | 32'h200);
    for (int i = 0; i < 100 && busy_n !== 1'b0; i++) @(negedge ref_clk);
    rd(ADDR_STATUS, st);
    chk("status", 32'h3, st & 32'hF);
    if (m == MODE_SINGLE) begin
      // retrigger and reconfigure mid-readout: both must be without effect
      for (int i = 0; i < 20000 && eq.size() < 1; i++) @(negedge ref_clk);
      pulse();
      wr(ADDR_CTRL, 32'h200 | 32'(MODE_VIDEO));
    end
    if (m == MODE_VIDEO) begin
      for (int i = 0; i < 40000 && eq.size() < 2; i++) @(negedge ref_clk);
      wr(ADDR_CTRL, ctl & ~32'h3);
    end
    for (int i = 0; i < 60000 && busy_n !== 1'b1; i++) @(negedge ref_clk);
    repeat (3) @(negedge ref_clk);
    chk("exposures", f, eq.size());
    chk("first exposure", n, eq[0]);
    if (m != MODE_SINGLE) chk("second exposure", (m == MODE_DUAL) ? r : n, eq[1]);
    chk("busy runs", 1, bq.size());
    chk("busy length", (m == MODE_SINGLE) ? n + r :
      ((m == MODE_DUAL) ? n + DEAD_CYC + 2 * r : 2 * n + 2 * r), bq[0]);
    chk("readout cycles", f * r, rsum);
    chk("pixels", f * r, pix_cnt - k);
    chk("light pulses", f, pulses - p);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // main sequence
  initial begin
    void'($urandom(10167));
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(ADDR_CTRL, v);
    chk("ctrl reset", 32'h0, v);
    rd(ADDR_EXP, v);
    chk("exp reset", 32'(RST_EXP_US), v);
    rd(8'h0C, v);
    chk("unmapped", 32'h0, v);
    run(MODE_SINGLE, VERTICAL_BIN_FOUR, SENS_SMALL_A, 5, 1'b1);
    run(MODE_SINGLE, VERTICAL_BIN_TWO, SENS_SMALL_A, $urandom_range(40, 10), 1'b0);
    run(MODE_SINGLE, VERTICAL_BIN_FOUR, SENS_SMALL_B, $urandom_range(40, 10), 1'b1);
    run(MODE_DUAL, VERTICAL_BIN_FOUR, SENS_SMALL_A, $urandom_range(40, 10), 1'b0);
    run(MODE_DUAL, VERTICAL_BIN_FOUR, SENS_SMALL_B, $urandom_range(40, 10), 1'b1);
    run(MODE_VIDEO, VERTICAL_BIN_FOUR, SENS_SMALL_A, $urandom_range(40, 10), 1'b1);
    chk("first colour", 0, bad_first);
    results();
  end

  // watchdog: the runs need about 60k cycles, so 80k means a hang
  initial begin
    #4000000;
    n_fail++;
    results();
  end
endmodule
